/* File: shared/shx_consts.svh */
// Purpose: constants of the hex record parser and checksum unit
// Assumes: included by bare name after the package
// Notes: record fields are binary bytes, not ASCII
`ifndef SHX_CONSTS_SVH
`define SHX_CONSTS_SVH

// ==================================================
// record framing
`define SHX_MARK 8'h3A
`define SHX_TYPE_DATA 8'h00
`define SHX_TYPE_END 8'h01
`define SHX_TYPE_EXT 8'h02
`define SHX_EXT_LEN 8'h02
`define SHX_END_LEN 8'h00
`define SHX_EXT_OFF 16'h0000
`define SHX_SEG_LIMIT 16'h2000

// ==================================================
// response byte windows, 1-based byte numbers
`define SHX_TXWIN_FIRST 8'h09
`define SHX_ID_LAST 8'h12
`define SHX_STAT_LAST 8'h0C

// ==================================================
// last reply byte index; sum-only replies start at the high byte, index 1
`define SHX_REPLY_LAST_WR 2'h2
`define SHX_REPLY_LAST_SUM 2'h2

`endif

/* File: shared/shx_pkg.sv */
// Purpose: types of the hex record parser and checksum unit
// Assumes: nothing
// Notes: constants live in shx_consts.svh
package shx_pkg;

    // ==================================================
    // commands that end in a checksum reply
    typedef enum logic [2:0] {
        CMD_ERASE,
        CMD_WRITE,
        CMD_SUMOUT,
        CMD_READ,
        CMD_RAM,
        CMD_PRODID,
        CMD_STATUS
    } shx_cmd_t;

    // ==================================================
    // parser and reply states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_MARK,
        ST_LEN,
        ST_OFFH,
        ST_OFFL,
        ST_TYPE,
        ST_DATA,
        ST_CSUM,
        ST_MEM,
        ST_TXMON,
        ST_REPLY,
        ST_HALT
    } shx_state_t;

endpackage

/* File: src/shx_byte_sum.sv */
// Purpose: sixteen-bit byte-sum accumulator
// Assumes: clear and add never coincide with intent to keep old sum
// Notes: wraps on overflow; clear takes priority
`timescale 1ns/1ps

module shx_byte_sum (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clr,
    input wire logic add_en,
    input wire logic [7:0] add_byte,
    output logic [15:0] sum_q
);

    // ==================================================
    // accumulator
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_q <= 16'h0000;
        end else if (clr) begin
            sum_q <= 16'h0000;
        end else if (add_en) begin
            sum_q <= sum_q + {8'h00, add_byte};
        end
    end

endmodule // shx_byte_sum

/* File: src/shx_record_checksum.sv */
// Purpose: binary hex record parser and command checksum unit
// Assumes: rx bytes, memory scan bytes and response bytes arrive synchronous to clk
// Notes: halted state is left only by reset
`timescale 1ns/1ps
`include "shx_consts.svh"

// Operation
// - every listed command ends with a two-byte checksum reply; write sends an overwrite byte before it.
// - checksum adds covered data bytes one byte at a time.
// - erase sums the erased region, delivered as the memory scan stream.
// - write and sum output sum the whole flash scan, not record fields.
// - read sums exactly the bytes read out.
// - RAM loader sums only received payload bytes, not framing.
// - product id sums response bytes nine through eighteen.
// - status output sums response bytes nine through twelve.
// - after a record checksum, discard bytes until the next start mark.
// - after end record, write replies three bytes, RAM loader two.
// - receive or format error halts silently.
// - record type other than data, end or extended is an error.
// - record checksum must make field byte sum zero.
// - extended record length other than two is an error.
// - extended record nonzero offset is an error.
// - data record after segment above limit is an error.
// - end record with nonzero length is an error.
// - data record big-endian offset, extended record big-endian segment.
module shx_record_checksum
    import shx_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_start,
    input wire shx_cmd_t cmd_kind,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_err,
    input wire logic mem_valid,
    input wire logic [7:0] mem_byte,
    input wire logic mem_last,
    input wire logic [7:0] ovw_byte,
    input wire logic tx_mon_valid,
    input wire logic [7:0] tx_mon_data,
    input wire logic reply_ready,
    output logic reply_valid,
    output logic [7:0] reply_byte,
    output logic scan_req_q,
    output logic data_valid_q,
    output logic [19:0] data_addr_q,
    output logic [7:0] data_byte_q,
    output logic busy,
    output logic halted
);

    // ==================================================
    // declarations
    shx_state_t st_q, st_d;
    shx_cmd_t cmd_q;
    logic [7:0] len_q, type_q, cnt_q, rec_sum_q, ovw_q, tx_idx_q;
    logic [15:0] off_q, seg_q, seg_new_q;
    logic seg_over_q;
    logic [1:0] rep_idx_q;
    logic [15:0] sum_q;
    logic parsing, rx_byte, fmt_err, type_err, hdr_err, csum_err;
    logic sum_clr, sum_add;
    logic [7:0] sum_byte, tx_num, tx_last;
    logic [1:0] rep_last;

    // true when the field bytes plus the check byte sum to zero
    function automatic logic rec_csum_ok(input logic [7:0] acc, input logic [7:0] chk);
        logic [7:0] t;
        t = acc + chk;
        return t == 8'h00;
    endfunction

    // ==================================================
    // error detection
    assign parsing = (st_q == ST_MARK) || (st_q == ST_LEN) || (st_q == ST_OFFH) ||
                     (st_q == ST_OFFL) || (st_q == ST_TYPE) || (st_q == ST_DATA) ||
                     (st_q == ST_CSUM);
    assign rx_byte = parsing && rx_valid;
    // length and offset are already held when the type byte arrives
    assign type_err = (rx_data != `SHX_TYPE_DATA) && (rx_data != `SHX_TYPE_END) &&
                      (rx_data != `SHX_TYPE_EXT);
    assign hdr_err = ((rx_data == `SHX_TYPE_EXT) &&
                      ((len_q != `SHX_EXT_LEN) || (off_q != `SHX_EXT_OFF))) ||
                     ((rx_data == `SHX_TYPE_END) && (len_q != `SHX_END_LEN)) ||
                     ((rx_data == `SHX_TYPE_DATA) && seg_over_q);
    assign csum_err = !rec_csum_ok(rec_sum_q, rx_data);
    assign fmt_err = rx_byte && (rx_err ||
                     ((st_q == ST_TYPE) && (type_err || hdr_err)) ||
                     ((st_q == ST_CSUM) && csum_err));

    assign tx_num = tx_idx_q + 8'h01;
    assign tx_last = (cmd_q == CMD_PRODID) ? `SHX_ID_LAST : `SHX_STAT_LAST;
    assign rep_last = (cmd_q == CMD_WRITE) ? `SHX_REPLY_LAST_WR : `SHX_REPLY_LAST_SUM;

    // ==================================================
    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (cmd_start) begin
                    case (cmd_kind)
                        CMD_WRITE, CMD_RAM: st_d = ST_MARK;
                        CMD_PRODID, CMD_STATUS: st_d = ST_TXMON;
                        default: st_d = ST_MEM;
                    endcase
                end
            end
            ST_MARK: begin
                if (rx_valid && (rx_data == `SHX_MARK)) begin
                    st_d = ST_LEN;
                end
            end
            ST_LEN: if (rx_valid) st_d = ST_OFFH;
            ST_OFFH: if (rx_valid) st_d = ST_OFFL;
            ST_OFFL: if (rx_valid) st_d = ST_TYPE;
            ST_TYPE: begin
                if (rx_valid) begin
                    st_d = (len_q == 8'h00) ? ST_CSUM : ST_DATA;
                end
            end
            ST_DATA: begin
                if (rx_valid && (cnt_q == 8'h01)) begin
                    st_d = ST_CSUM;
                end
            end
            ST_CSUM: begin
                if (rx_valid) begin
                    if (type_q != `SHX_TYPE_END) begin
                        st_d = ST_MARK;
                    end else if (cmd_q == CMD_WRITE) begin
                        st_d = ST_MEM;
                    end else begin
                        st_d = ST_REPLY;
                    end
                end
            end
            ST_MEM: begin
                if (mem_valid && mem_last) begin
                    st_d = ST_REPLY;
                end
            end
            ST_TXMON: begin
                if (tx_mon_valid && (tx_num == tx_last)) begin
                    st_d = ST_REPLY;
                end
            end
            ST_REPLY: begin
                if (reply_ready && (rep_idx_q == rep_last)) begin
                    st_d = ST_IDLE;
                end
            end
            ST_HALT: st_d = ST_HALT;
            default: st_d = ST_IDLE;
        endcase
        if (fmt_err) begin
            st_d = ST_HALT;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_q <= CMD_ERASE;
        end else if ((st_q == ST_IDLE) && cmd_start) begin
            cmd_q <= cmd_kind;
        end
    end

    // ==================================================
    // record fields
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            len_q <= 8'h00;
            off_q <= 16'h0000;
            type_q <= 8'h00;
            cnt_q <= 8'h00;
        end else if (rx_valid) begin
            case (st_q)
                ST_LEN: len_q <= rx_data;
                ST_OFFH: off_q <= {rx_data, off_q[7:0]};
                ST_OFFL: off_q <= {off_q[15:8], rx_data};
                ST_TYPE: begin
                    type_q <= rx_data;
                    cnt_q <= len_q;
                end
                ST_DATA: cnt_q <= cnt_q - 8'h01;
                default: cnt_q <= cnt_q;
            endcase
        end
    end

    // field byte sum, restarted by each start mark
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rec_sum_q <= 8'h00;
        end else if ((st_q == ST_MARK) && rx_valid) begin
            rec_sum_q <= 8'h00;
        end else if (rx_valid && (st_q inside {ST_LEN, ST_OFFH, ST_OFFL, ST_TYPE, ST_DATA})) begin
            rec_sum_q <= rec_sum_q + rx_data;
        end
    end

    // segment is taken only once its record checksum has passed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seg_new_q <= 16'h0000;
            seg_q <= 16'h0000;
            seg_over_q <= 1'b0;
        end else if ((st_q == ST_IDLE) && cmd_start) begin
            seg_q <= 16'h0000;
            seg_over_q <= 1'b0;
        end else if (rx_valid && (st_q == ST_DATA) && (type_q == `SHX_TYPE_EXT)) begin
            seg_new_q <= {seg_new_q[7:0], rx_data};
        end else if (rx_valid && (st_q == ST_CSUM) && (type_q == `SHX_TYPE_EXT) && !csum_err) begin
            seg_q <= seg_new_q;
            seg_over_q <= seg_new_q > `SHX_SEG_LIMIT;
        end
    end

    // ==================================================
    // payload out; the record is only verified after its last byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_valid_q <= 1'b0;
            data_addr_q <= 20'h00000;
            data_byte_q <= 8'h00;
        end else begin
            data_valid_q <= rx_valid && !rx_err && (st_q == ST_DATA) &&
                            (type_q == `SHX_TYPE_DATA);
            if (rx_valid && (st_q == ST_TYPE)) begin
                data_addr_q <= {seg_q, 4'h0} + {4'h0, off_q};
            end else if (data_valid_q) begin
                data_addr_q <= data_addr_q + 20'h00001;
            end
            if (rx_valid && (st_q == ST_DATA)) begin
                data_byte_q <= rx_data;
            end
        end
    end

    // ==================================================
    // command checksum
    always_comb begin
        sum_clr = (st_q == ST_IDLE) && cmd_start;
        sum_add = 1'b0;
        sum_byte = 8'h00;
        if ((st_q == ST_MEM) && mem_valid) begin
            sum_add = 1'b1;
            sum_byte = mem_byte;
        end else if ((st_q == ST_DATA) && rx_valid && (cmd_q == CMD_RAM) &&
                     (type_q == `SHX_TYPE_DATA)) begin
            sum_add = 1'b1;
            sum_byte = rx_data;
        end else if ((st_q == ST_TXMON) && tx_mon_valid && (tx_num >= `SHX_TXWIN_FIRST)) begin
            sum_add = 1'b1;
            sum_byte = tx_mon_data;
        end
    end

    shx_byte_sum u_sum (
        .clk(clk),
        .reset_n(reset_n),
        .clr(sum_clr),
        .add_en(sum_add),
        .add_byte(sum_byte),
        .sum_q(sum_q)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_idx_q <= 8'h00;
        end else if (sum_clr) begin
            tx_idx_q <= 8'h00;
        end else if ((st_q == ST_TXMON) && tx_mon_valid) begin
            tx_idx_q <= tx_num;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovw_q <= 8'h00;
        end else if ((st_q == ST_MEM) && mem_valid && mem_last) begin
            ovw_q <= ovw_byte;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scan_req_q <= 1'b0;
        end else begin
            scan_req_q <= (st_d == ST_MEM) && (st_q != ST_MEM);
        end
    end

    // ==================================================
    // reply: overwrite byte for write only, then sum high, then low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rep_idx_q <= 2'h0;
        end else if (st_q != ST_REPLY) begin
            rep_idx_q <= (cmd_q == CMD_WRITE) ? 2'h0 : 2'h1;
        end else if (reply_ready) begin
            rep_idx_q <= rep_idx_q + 2'h1;
        end
    end

    assign reply_valid = (st_q == ST_REPLY);
    always_comb begin
        case (rep_idx_q)
            2'h0: reply_byte = ovw_q;
            2'h1: reply_byte = sum_q[15:8];
            default: reply_byte = sum_q[7:0];
        endcase
    end

    assign busy = (st_q != ST_IDLE) && (st_q != ST_HALT);
    assign halted = (st_q == ST_HALT);

    // ==================================================
    // checks
    property p_rx_err_halts;
        @(posedge clk) disable iff (!reset_n)
        (rx_byte && rx_err) |=> (st_q == ST_HALT) && !reply_valid;
    endproperty
    a_rx_err_halts: assert property (p_rx_err_halts) else $error("rx error did not halt");

    property p_bad_type;
        @(posedge clk) disable iff (!reset_n)
        (rx_valid && (st_q == ST_TYPE) && (rx_data > 8'h02)) |=> halted;
    endproperty
    a_bad_type: assert property (p_bad_type) else $error("bad record type accepted");

    property p_csum_bad;
        @(posedge clk) disable iff (!reset_n)
        (rx_valid && (st_q == ST_CSUM) && ((rec_sum_q + rx_data) != 8'h00)) |=> halted;
    endproperty
    a_csum_bad: assert property (p_csum_bad) else $error("record checksum mismatch accepted");

    property p_ext_len;
        @(posedge clk) disable iff (!reset_n)
        (rx_valid && (st_q == ST_TYPE) && (rx_data == 8'h02) && (len_q != 8'h02)) |=> halted;
    endproperty
    a_ext_len: assert property (p_ext_len) else $error("extended length not checked");

    property p_ext_off;
        @(posedge clk) disable iff (!reset_n)
        (rx_valid && (st_q == ST_TYPE) && (rx_data == 8'h02) && (off_q != 16'h0000)) |=> halted;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("extended offset not checked");

    property p_end_len;
        @(posedge clk) disable iff (!reset_n)
        (rx_valid && (st_q == ST_TYPE) && (rx_data == 8'h01) && (len_q != 8'h00)) |=> halted;
    endproperty
    a_end_len: assert property (p_end_len) else $error("end record length not checked");

    property p_seg_limit;
        @(posedge clk) disable iff (!reset_n)
        (rx_valid && (st_q == ST_TYPE) && (rx_data == 8'h00) && (seg_q > 16'h2000)) |=> halted;
    endproperty
    a_seg_limit: assert property (p_seg_limit) else $error("segment limit not checked");

    property p_wait_discard;
        @(posedge clk) disable iff (!reset_n)
        (st_q == ST_MARK && rx_valid && !rx_err && rx_data != 8'h3A) |=> (st_q == ST_MARK);
    endproperty
    a_wait_discard: assert property (p_wait_discard) else $error("byte left wait state");

    sequence s_reply_hi;
        reply_valid && (rep_idx_q == 2'h1) && reply_ready;
    endsequence
    sequence s_reply_lo;
        reply_valid && (reply_byte == $past(sum_q[7:0]));
    endsequence
    property p_hi_then_lo;
        @(posedge clk) disable iff (!reset_n)
        s_reply_hi |-> (reply_byte == sum_q[15:8]) ##1 s_reply_lo;
    endproperty
    a_hi_then_lo: assert property (p_hi_then_lo) else $error("checksum byte order wrong");

    property p_ram_reply_len;
        @(posedge clk) disable iff (!reset_n)
        ((st_q != ST_REPLY) ##1 (reply_valid && (cmd_q == CMD_RAM))) |-> (rep_idx_q == 2'h1);
    endproperty
    a_ram_reply_len: assert property (p_ram_reply_len) else $error("RAM reply not two bytes");

endmodule // shx_record_checksum

/* File: verif/shx_ctl_model.sv */
// Purpose: programming controller model facing the record parser
// Assumes: bytes change at the falling edge, one byte per cycle
// Notes: reply sink stalls three cycles of four when slow is set
`timescale 1ns/1ps

module shx_ctl_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic reply_valid,
    input wire logic [7:0] reply_byte,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_err,
    output logic reply_ready
);
    logic [7:0] rep_q [$];
    logic [1:0] stall_q;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_err = 1'b0;
        reply_ready = 1'b0;
        stall_q = 2'h0;
    end

    // ==================================================
    // reply sink
    // reply outputs settle after the rising edge, so the transfer of the
    // coming edge is taken here, away from the edge that moves them
    always @(negedge clk) begin
        stall_q = stall_q + 2'h1;
        reply_ready = !slow || stall_q == 2'h0;
        if (reply_valid && reply_ready) begin
            rep_q.push_back(reply_byte);
        end
    end

    // ==================================================
    // byte sender
    task automatic send_byte(input logic [7:0] b, input logic err);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = b;
        rx_err = err;
    endtask

    // idle line shows the inverse so a stale byte is never mistaken
    task automatic idle();
        @(negedge clk);
        rx_valid = 1'b0;
        rx_err = 1'b0;
        rx_data = ~rx_data;
    endtask

    task automatic send_rec(input int junk, input logic [7:0] typ, input logic [15:0] off,
                            input logic [7:0] pl [$], input logic bad);
        logic [7:0] s;
        s = 8'(pl.size()) + off[15:8] + off[7:0] + typ;
        foreach (pl[i]) s = s + pl[i];
        repeat (junk) send_byte(8'hC5, 1'b0);
        send_byte(8'h3A, 1'b0);
        send_byte(8'(pl.size()), 1'b0);
        send_byte(off[15:8], 1'b0);
        send_byte(off[7:0], 1'b0);
        send_byte(typ, 1'b0);
        foreach (pl[i]) send_byte(pl[i], 1'b0);
        send_byte((8'h00 - s) ^ {7'h00, bad}, 1'b0);
        idle();
    endtask
endmodule // shx_ctl_model

/* File: verif/serial_prog_hex_record_checksum_test.sv */
// Purpose: self-checking bench of the record parser and checksum unit
// Assumes: seed 39, inputs change at the falling edge
// Notes: error cases each need a reset since halt is sticky
`timescale 1ns/1ps

module serial_prog_hex_record_checksum_test
    import shx_pkg::*;
;
    logic clk, reset_n, cmd_start, rx_valid, rx_err, mem_valid, mem_last;
    logic tx_mon_valid, reply_ready, reply_valid, scan_req_q, data_valid_q;
    logic busy, halted, slow, mon_on, scan_seen;
    shx_cmd_t cmd_kind;
    logic [7:0] rx_data, mem_byte, ovw_byte, tx_mon_data, reply_byte, data_byte_q;
    logic [19:0] data_addr_q;
    logic [27:0] exp_q [$];
    logic [7:0] p [$], mq [$], eq [$];
    logic [15:0] s;
    int err_count, num_checks, seed;
    shx_cmd_t kinds [3] = '{CMD_ERASE, CMD_SUMOUT, CMD_READ};

    shx_record_checksum dut_u (.clk(clk), .reset_n(reset_n), .cmd_start(cmd_start),
        .cmd_kind(cmd_kind), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
        .mem_valid(mem_valid), .mem_byte(mem_byte), .mem_last(mem_last),
        .ovw_byte(ovw_byte), .tx_mon_valid(tx_mon_valid), .tx_mon_data(tx_mon_data),
        .reply_ready(reply_ready), .reply_valid(reply_valid), .reply_byte(reply_byte),
        .scan_req_q(scan_req_q), .data_valid_q(data_valid_q), .data_addr_q(data_addr_q),
        .data_byte_q(data_byte_q), .busy(busy), .halted(halted));

    shx_ctl_model ctl_u (.clk(clk), .slow(slow), .reply_valid(reply_valid),
        .reply_byte(reply_byte), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
        .reply_ready(reply_ready));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==================================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            $display("mismatch at %0t: %s", $time, m);
            err_count++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #(40 * 40000);
        $display("mismatch at %0t: watchdog", $time);
        err_count++;
        end_of_test();
    end

    always @(negedge clk) begin
        if (scan_req_q === 1'b1) scan_seen = 1'b1;
        if (mon_on && data_valid_q === 1'b1) begin
            check(exp_q.size() > 0, 1, "unexpected payload");
            if (exp_q.size() > 0) check({data_addr_q, data_byte_q}, exp_q.pop_front(), "payload");
        end
    end

    // ==================================================
    // stimulus tasks
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        ctl_u.rep_q.delete();
        exp_q.delete();
    endtask

    task automatic start(input shx_cmd_t k);
        scan_seen = 1'b0;
        slow = 1'($random(seed));
        @(negedge clk);
        cmd_start = 1'b1;
        cmd_kind = k;
        @(negedge clk);
        cmd_start = 1'b0;
        check(busy, 1, "busy after start");
    endtask

    // covered payload also feeds the expected running sum
    task automatic drec(input logic [15:0] seg, input logic [15:0] off, inout logic [15:0] t);
        logic [7:0] q [$];
        logic [7:0] b;
        repeat (1 + ($unsigned($random(seed)) % 12)) begin
            b = 8'($random(seed));
            q.push_back(b);
            exp_q.push_back({{seg, 4'h0} + {4'h0, off} + 20'(q.size() - 1), b});
            t = t + {8'h00, b};
        end
        ctl_u.send_rec($unsigned($random(seed)) % 3, 8'h00, off, q, 1'b0);
    endtask

    task automatic ext(input logic [15:0] seg);
        logic [7:0] q [$];
        q = {seg[15:8], seg[7:0]};
        ctl_u.send_rec(0, 8'h02, 16'h0000, q, 1'b0);
    endtask

    task automatic mem_send(input logic [7:0] q [$]);
        for (int i = 0; i < 20 && !scan_seen; i++) @(negedge clk);
        check(scan_seen, 1, "scan request");
        foreach (q[i]) begin
            @(negedge clk);
            mem_valid = 1'b1;
            mem_byte = q[i];
            mem_last = i == q.size() - 1;
        end
        @(negedge clk);
        mem_valid = 1'b0;
        mem_last = 1'b0;
        mem_byte = ~mem_byte;
    endtask

    task automatic tx_send(input int n, output logic [15:0] t);
        logic [7:0] b;
        t = 16'h0000;
        for (int i = 1; i <= n; i++) begin
            b = 8'($random(seed));
            @(negedge clk);
            tx_mon_valid = 1'b1;
            tx_mon_data = b;
            if (i >= 9) t = t + {8'h00, b};
        end
        @(negedge clk);
        tx_mon_valid = 1'b0;
        tx_mon_data = ~tx_mon_data;
    endtask

    // controller stays silent on rx while the reply drains
    task automatic get_reply(input logic [7:0] q [$]);
        for (int i = 0; i < 300 && ctl_u.rep_q.size() < q.size(); i++) @(negedge clk);
        for (int i = 0; i < 10 && busy !== 1'b0; i++) @(negedge clk);
        check(ctl_u.rep_q.size(), q.size(), "reply length");
        foreach (q[i]) if (i < ctl_u.rep_q.size()) check(ctl_u.rep_q[i], q[i], "reply byte");
        check(busy, 0, "busy after reply");
        ctl_u.rep_q.delete();
    endtask

    // ==================================================
    // main sequence
    initial begin
        {cmd_start, mem_valid, mem_last, tx_mon_valid, slow} = 5'h00;
        {mem_byte, tx_mon_data, ovw_byte} = 24'h000000;
        cmd_kind = CMD_RAM;
        err_count = 0;
        num_checks = 0;
        seed = 39;
        mon_on = 1'b1;
        scan_seen = 1'b0;
        do_reset();
        start(CMD_RAM);
        s = 16'h0000;
        drec(16'h0000, 16'h0100, s);
        ext(16'h2000); // limit itself accepted
        drec(16'h2000, 16'h1230, s);
        p.delete();
        ctl_u.send_rec(0, 8'h01, 16'h0000, p, 1'b0);
        eq = {s[15:8], s[7:0]};
        get_reply(eq);
        start(CMD_WRITE);
        s = 16'h0000;
        drec(16'h0000, 16'h0040, s);
        ctl_u.send_rec(1, 8'h01, 16'h0000, p, 1'b0);
        ovw_byte = 8'($random(seed));
        mq.delete();
        s = 16'h0000;
        repeat (30) mq.push_back(8'($random(seed)));
        foreach (mq[i]) s = s + {8'h00, mq[i]};
        mem_send(mq);
        eq = {ovw_byte, s[15:8], s[7:0]};
        get_reply(eq);
        for (int k = 0; k < 3; k++) begin
            start(kinds[k]);
            mq.delete();
            if (k == 0) mq = {8'hA1, 8'hB2, 8'hC3, 8'hD4};
            if (k == 1) repeat (17) mq.push_back(8'($random(seed)));
            if (k == 2) repeat (260) mq.push_back(8'hFF);
            s = 16'h02FC;
            if (k == 0) s = 16'h02EA;
            if (k == 1) begin
                s = 16'h0000;
                foreach (mq[i]) s = s + {8'h00, mq[i]};
            end
            mem_send(mq);
            eq = {s[15:8], s[7:0]};
            get_reply(eq);
        end
        for (int k = 0; k < 2; k++) begin
            start(k == 0 ? CMD_PRODID : CMD_STATUS);
            tx_send(k == 0 ? 18 : 12, s);
            eq = {s[15:8], s[7:0]};
            get_reply(eq);
        end
        mon_on = 1'b0;
        for (int k = 0; k < 7; k++) begin
            do_reset();
            start(CMD_RAM);
            p = {8'h00, 8'h10, 8'h00};
            case (k)
                0: ctl_u.send_rec(0, 8'h03, 16'h0000, p, 1'b0);
                1: ctl_u.send_rec(0, 8'h00, 16'h0040, p, 1'b1);
                2: ctl_u.send_rec(0, 8'h02, 16'h0000, p, 1'b0);
                3: begin
                    p = {8'h00, 8'h10};
                    ctl_u.send_rec(0, 8'h02, 16'h0010, p, 1'b0);
                end
                4: begin
                    ext(16'h2001);
                    ctl_u.send_rec(0, 8'h00, 16'h0000, p, 1'b0);
                end
                5: ctl_u.send_rec(0, 8'h01, 16'h0000, p, 1'b0);
                default: begin
                    ctl_u.send_byte(8'h3A, 1'b1);
                    ctl_u.idle();
                end
            endcase
            repeat (4) @(negedge clk);
            check(halted, 1, "halt after error");
            check(reply_valid, 0, "silent after error");
            cmd_start = 1'b1;
            @(negedge clk);
            cmd_start = 1'b0;
            check(busy, 0, "command taken while halted");
        end
        end_of_test();
    end
endmodule // serial_prog_hex_record_checksum_test
